// File: hw/scss_pkg.sv
// package for the system clock source selector: offsets, mode fields, limits, timing
// assumes a 200 MHz core clock and a plain strobe register port
package scss_pkg;

    // register offsets (byte addresses)
    localparam logic [3:0] SCSS_OFF_MODE  = 4'h0;
    localparam logic [3:0] SCSS_OFF_FREQ  = 4'h4;
    localparam logic [3:0] SCSS_OFF_XIN   = 4'h8;
    localparam logic [3:0] SCSS_OFF_STAT  = 4'hC;

    // mode byte fields
    localparam int SCSS_MODE_RESET_BIT = 7;
    localparam int SCSS_MODE_PLL_BIT   = 6;
    localparam int SCSS_MODE_OSC_BIT   = 5;
    localparam int SCSS_MODE_DRV_LSB   = 3;
    localparam int SCSS_MODE_SEL_LSB   = 0;

    // source select codes
    localparam logic [2:0] SCSS_SEL_FAST = 3'h0;
    localparam logic [2:0] SCSS_SEL_SLOW = 3'h1;
    localparam logic [2:0] SCSS_SEL_XIN  = 3'h2;
    localparam logic [2:0] SCSS_SEL_X1   = 3'h3;
    localparam logic [2:0] SCSS_SEL_X2   = 3'h4;
    localparam logic [2:0] SCSS_SEL_X4   = 3'h5;
    localparam logic [2:0] SCSS_SEL_X8   = 3'h6;
    localparam logic [2:0] SCSS_SEL_X16  = 3'h7;

    // crystal drive codes
    localparam logic [1:0] SCSS_DRV_NONE = 2'h0;
    localparam logic [1:0] SCSS_DRV_LOW  = 2'h1;
    localparam logic [1:0] SCSS_DRV_MED  = 2'h2;
    localparam logic [1:0] SCSS_DRV_HIGH = 2'h3;

    // status bits
    localparam int SCSS_STAT_BUSY    = 0;
    localparam int SCSS_STAT_RANGE   = 1;
    localparam int SCSS_STAT_REFUSED = 2;
    localparam int SCSS_STAT_SRC_LSB = 4;

    // reset values
    localparam logic [7:0]  SCSS_MODE_RESET = 8'h00;
    localparam logic [31:0] SCSS_XIN_RESET  = 32'h0000_0000;

    // frequencies in Hz
    localparam logic [31:0] SCSS_FAST_NOM_HZ = 32'h00B7_1B00;
    localparam logic [31:0] SCSS_FAST_MIN_HZ = 32'h007A_1200;
    localparam logic [31:0] SCSS_FAST_MAX_HZ = 32'h0131_2D00;
    localparam logic [31:0] SCSS_SLOW_NOM_HZ = 32'h0000_4E20;
    localparam logic [31:0] SCSS_SLOW_MIN_HZ = 32'h0000_32C8;
    localparam logic [31:0] SCSS_SLOW_MAX_HZ = 32'h0000_80E8;
    localparam logic [31:0] SCSS_XIN_MAX_HZ  = 32'h04C4_B400;
    localparam logic [31:0] SCSS_LOW_MIN_HZ  = 32'h003D_0900;
    localparam logic [31:0] SCSS_LOW_MAX_HZ  = 32'h00F4_2400;
    localparam logic [31:0] SCSS_MED_MIN_HZ  = 32'h007A_1200;
    localparam logic [31:0] SCSS_MED_MAX_HZ  = 32'h01E8_4800;
    localparam logic [31:0] SCSS_HIGH_MIN_HZ = 32'h0131_2D00;
    localparam logic [31:0] SCSS_HIGH_MAX_HZ = 32'h04C4_B400;

    // the pll always runs at sixteen times its reference
    localparam int SCSS_PLL_LOG2 = 4;

    // timing
    localparam int SCSS_CLK_PERIOD_NS  = 5;
    localparam int SCSS_SWITCH_TIME_NS = 75000;
    localparam int SCSS_SWITCH_CYCLES  = SCSS_SWITCH_TIME_NS / SCSS_CLK_PERIOD_NS;

    // frequency word lives in long 0
    localparam logic [1:0] SCSS_FREQ_LONG = 2'h0;

    typedef enum logic [3:0] {
        SCSS_ST_RUN  = 4'b0001,
        SCSS_ST_WAIT = 4'b0010,
        SCSS_ST_SWAP = 4'b0100,
        SCSS_ST_REL  = 4'b1000
    } scss_state_t;

endpackage

// File: hw/scss_word_mem.sv
// small word memory holding the system frequency word at long 0
// assumes one write and one read port, read data registered
`timescale 1ns/1ps
module scss_word_mem #(
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [31:0]   wdata,
    // read port
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [31:0]   rdata_q
);
    typedef struct packed {
        logic [DEPTH-1:0][31:0] words;
        logic [31:0]            rdata;
    } scss_mem_t;

    scss_mem_t mem_q;
    scss_mem_t mem_d;

    always_comb begin
        mem_d = mem_q;
        if (we) begin
            mem_d.words[waddr] = wdata;
        end
        if (re) begin
            mem_d.rdata = mem_q.words[raddr];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mem_q <= '0;
        end else begin
            mem_q <= mem_d;
        end
    end

    assign rdata_q = mem_q.rdata;
endmodule

// File: hw/scss_top.sv
// system clock source selector: mode byte, frequency word, glitch-free source switch
// assumes oscillator and pll levels arrive synchronous to the 200 MHz clock
`timescale 1ns/1ps
module scss_top
    import scss_pkg::*;
#(
    parameter logic [7:0] STARTUP_MODE    = SCSS_MODE_RESET,
    parameter int         SWITCH_CYCLES_P = SCSS_SWITCH_CYCLES
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // oscillator levels
    input  wire logic        fast_osc_in,
    input  wire logic        slow_osc_in,
    input  wire logic        crystal_input_pin,
    input  wire logic        pll_vco_in,
    // crystal output pin and analog controls
    output logic             crystal_output_pin_o,
    output logic             crystal_output_pin_oe,
    output logic      [1:0]  feedback_load,
    output logic             oscillator_enable_bit,
    output logic             multiplier_enable_bit,
    // system clock
    output logic             sys_clk_out,
    output logic             switch_busy
);
    typedef struct packed {
        scss_state_t st;
        logic [7:0]  mode;
        logic [2:0]  act;
        logic [31:0] xin;
        logic [31:0] cnt;
        logic        hold;
        logic        sysclk;
        logic [3:0]  div;
        logic        vco;
        logic        refused;
        logic        init;
        logic        rd_sel;
        logic [31:0] rdata;
        logic        xo;
    } scss_regs_t;

    scss_regs_t  r_q;
    scss_regs_t  r_d;
    logic        ram_we;
    logic [31:0] ram_wdata;
    logic [31:0] ram_rdata;
    logic [2:0]  new_sel;
    logic        mode_wr;
    logic        range_err;

    function automatic logic [2:0] sel_of(input logic [7:0] m);
        return m[SCSS_MODE_SEL_LSB +: 3];
    endfunction

    function automatic logic [1:0] drv_of(input logic [7:0] m);
        return m[SCSS_MODE_DRV_LSB +: 2];
    endfunction

    // external sources need the oscillator, taps need the pll
    function automatic logic mode_ok(input logic [7:0] m);
        logic [2:0] s;
        s = sel_of(m);
        return !((s >= SCSS_SEL_XIN) && !m[SCSS_MODE_OSC_BIT]) &&
               !((s >= SCSS_SEL_X1) && !m[SCSS_MODE_PLL_BIT]);
    endfunction

    // reported frequency: taps come from the sixteen-times product
    function automatic logic [31:0] freq_of(input logic [2:0] s, input logic [31:0] x);
        logic [35:0] x16;
        x16 = {x, 4'h0};
        unique case (s)
            SCSS_SEL_FAST: return SCSS_FAST_NOM_HZ;
            SCSS_SEL_SLOW: return SCSS_SLOW_NOM_HZ;
            SCSS_SEL_XIN:  return x;
            SCSS_SEL_X1:   return x16[35:4];
            SCSS_SEL_X2:   return x16[34:3];
            SCSS_SEL_X4:   return x16[33:2];
            SCSS_SEL_X8:   return x16[32:1];
            SCSS_SEL_X16:  return x16[31:0];
        endcase
    endfunction

    // level of a source; internal ones never pass through the pll divider
    function automatic logic level_of(input logic [2:0] s, input scss_regs_t r);
        unique case (s)
            SCSS_SEL_FAST: return fast_osc_in;
            SCSS_SEL_SLOW: return slow_osc_in;
            SCSS_SEL_XIN:  return crystal_input_pin;
            SCSS_SEL_X1:   return r.div[3];
            SCSS_SEL_X2:   return r.div[2];
            SCSS_SEL_X4:   return r.div[1];
            SCSS_SEL_X8:   return r.div[0];
            SCSS_SEL_X16:  return r.vco;
        endcase
    endfunction

    always_comb begin
        logic [1:0] d;
        d = drv_of(r_q.mode);
        unique case (sel_of(r_q.mode))
            SCSS_SEL_FAST, SCSS_SEL_SLOW: range_err = 1'b0;
            default: begin
                unique case (d)
                    SCSS_DRV_NONE: range_err = r_q.xin > SCSS_XIN_MAX_HZ;
                    SCSS_DRV_LOW:  range_err = (r_q.xin < SCSS_LOW_MIN_HZ) ||
                                               (r_q.xin > SCSS_LOW_MAX_HZ);
                    SCSS_DRV_MED:  range_err = (r_q.xin < SCSS_MED_MIN_HZ) ||
                                               (r_q.xin > SCSS_MED_MAX_HZ);
                    SCSS_DRV_HIGH: range_err = (r_q.xin < SCSS_HIGH_MIN_HZ) ||
                                               (r_q.xin > SCSS_HIGH_MAX_HZ);
                endcase
            end
        endcase
    end

    assign new_sel = wdata[SCSS_MODE_SEL_LSB +: 3];
    assign mode_wr = wr && (addr == SCSS_OFF_MODE);

    always_comb begin
        r_d       = r_q;
        ram_we    = 1'b0;
        ram_wdata = '0;
        r_d.init  = 1'b0;
        r_d.rd_sel = 1'b0;
        // pll divider steps on each vco rise; taps up to x8 are its bits, x16 is the vco itself
        r_d.vco = pll_vco_in;
        if (pll_vco_in && !r_q.vco) begin
            r_d.div = r_q.div + 4'h1;
        end
        // crystal feedback amplifier: inverted input while a drive level is on
        r_d.xo = !crystal_input_pin;
        // start-up frequency word goes to long 0 on the first cycle
        if (r_q.init) begin
            ram_we    = 1'b1;
            ram_wdata = freq_of(sel_of(STARTUP_MODE), r_q.xin);
        end
        unique case (r_q.st)
            SCSS_ST_RUN: begin
            end
            SCSS_ST_WAIT: begin
                if (r_q.hold && !level_of(r_q.act, r_q)) begin
                    r_d.hold = 1'b0;
                end
                r_d.cnt = r_q.cnt + 32'h1;
                if (r_q.cnt == 32'(SWITCH_CYCLES_P - 1)) begin
                    r_d.st = SCSS_ST_SWAP;
                end
            end
            SCSS_ST_SWAP: begin
                // swap only while the old source is low, then mask the new one
                if (!level_of(r_q.act, r_q)) begin
                    r_d.act  = sel_of(r_q.mode);
                    r_d.hold = 1'b1;
                    r_d.st   = SCSS_ST_REL;
                end
            end
            SCSS_ST_REL: begin
                if (!level_of(r_q.act, r_q)) begin
                    r_d.hold = 1'b0;
                    r_d.st   = SCSS_ST_RUN;
                end
            end
        endcase
        // register writes; refused modes only set the refused flag and leave the rest as it was
        if (mode_wr) begin
            if (mode_ok(wdata[7:0])) begin
                r_d.mode  = wdata[7:0];
                ram_we    = 1'b1;
                ram_wdata = freq_of(new_sel, r_q.xin);
                if (new_sel != r_q.act) begin
                    r_d.st  = SCSS_ST_WAIT;
                    r_d.cnt = '0;
                end else begin
                    r_d.st  = r_q.hold ? SCSS_ST_REL : SCSS_ST_RUN;
                end
            end else begin
                r_d.refused = 1'b1;
            end
        end
        if (wr && (addr == SCSS_OFF_FREQ)) begin
            ram_we    = 1'b1;
            ram_wdata = wdata;
        end
        if (wr && (addr == SCSS_OFF_XIN)) begin
            r_d.xin = wdata;
        end
        // write one clears refused; a new refusal in the same cycle wins
        if (wr && (addr == SCSS_OFF_STAT) && wdata[SCSS_STAT_REFUSED] && !mode_wr) begin
            r_d.refused = 1'b0;
        end
        // the clock is a registered copy of the chosen source, masked by hold
        r_d.sysclk = level_of(r_q.act, r_q) && !r_q.hold;
        // read data, one cycle later
        if (rd) begin
            unique case (addr)
                SCSS_OFF_MODE: r_d.rdata = {24'h0, r_q.mode};
                SCSS_OFF_FREQ: r_d.rd_sel = 1'b1;
                SCSS_OFF_XIN:  r_d.rdata = r_q.xin;
                SCSS_OFF_STAT: begin
                    r_d.rdata = '0;
                    r_d.rdata[SCSS_STAT_BUSY]    = r_q.st != SCSS_ST_RUN;
                    r_d.rdata[SCSS_STAT_RANGE]   = range_err;
                    r_d.rdata[SCSS_STAT_REFUSED] = r_q.refused;
                    r_d.rdata[SCSS_STAT_SRC_LSB +: 3] = r_q.act;
                end
                default:       r_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r_q      <= '0;
            r_q.st   <= SCSS_ST_RUN;
            r_q.mode <= STARTUP_MODE;
            r_q.act  <= STARTUP_MODE[SCSS_MODE_SEL_LSB +: 3];
            r_q.xin  <= SCSS_XIN_RESET;
            r_q.init <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    scss_word_mem #(
        .DEPTH (4),
        .AW    (2)
    ) u_freq_mem (
        .clock   (clock),
        .rst_n   (rst_n),
        .we      (ram_we),
        .waddr   (SCSS_FREQ_LONG),
        .wdata   (ram_wdata),
        .re      (rd && (addr == SCSS_OFF_FREQ)),
        .raddr   (SCSS_FREQ_LONG),
        .rdata_q (ram_rdata)
    );

    // pin drive: off whenever no crystal drive level is chosen
    assign crystal_output_pin_oe = r_q.mode[SCSS_MODE_OSC_BIT] &&
                                   (drv_of(r_q.mode) != SCSS_DRV_NONE);
    assign crystal_output_pin_o  = r_q.xo && crystal_output_pin_oe;
    assign feedback_load         = crystal_output_pin_oe ? drv_of(r_q.mode) : SCSS_DRV_NONE;
    assign oscillator_enable_bit = r_q.mode[SCSS_MODE_OSC_BIT];
    assign multiplier_enable_bit = r_q.mode[SCSS_MODE_PLL_BIT];
    assign sys_clk_out           = r_q.sysclk;
    assign switch_busy           = r_q.st != SCSS_ST_RUN;
    assign rdata                 = r_q.rd_sel ? ram_rdata : r_q.rdata;

    mode_read_a: assert property (@(posedge clock) disable iff (!rst_n)
        (rd && addr == SCSS_OFF_MODE) |=> (rdata == {24'h0, $past(r_q.mode)}))
        else $error("mode read data wrong");
    freq_update_a: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_wr && mode_ok(wdata[7:0])) |=>
        (u_freq_mem.mem_q.words[0] == freq_of($past(new_sel), $past(r_q.xin))))
        else $error("frequency word not updated");
    fast_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        // the release edge still holds the flops in reset, so it is no follow cycle
        (rst_n && r_q.act == SCSS_SEL_FAST && !r_q.hold) |=>
        (sys_clk_out == $past(fast_osc_in)))
        else $error("fast source not followed");
    slow_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        (rst_n && r_q.act == SCSS_SEL_SLOW && !r_q.hold) |=>
        (sys_clk_out == $past(slow_osc_in)))
        else $error("slow source not followed");
    xo_quiet_a: assert property (@(posedge clock) disable iff (!rst_n)
        (drv_of(r_q.mode) == SCSS_DRV_NONE) |-> !crystal_output_pin_oe && feedback_load == 2'h0)
        else $error("output pin driven in input mode");
    pll_divider_a: assert property (@(posedge clock) disable iff (!rst_n)
        (pll_vco_in && !r_q.vco) |=> (r_q.div == $past(r_q.div) + 4'h1))
        else $error("pll divider did not step");
    refuse_mode_a: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_wr && !mode_ok(wdata[7:0])) |=> ($stable(r_q.mode) && r_q.refused))
        else $error("invalid mode accepted");
    switch_time_a: assert property (@(posedge clock) disable iff (!rst_n)
        (r_q.st == SCSS_ST_WAIT && r_q.cnt == 32'(SWITCH_CYCLES_P - 1) && !mode_wr)
        |=> (r_q.st == SCSS_ST_SWAP))
        else $error("switch delay wrong");
    glitch_free_a: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(r_q.act) |-> !sys_clk_out ##1 !sys_clk_out)
        else $error("pulse cut during swap");
    startup_word_a: assert property (@(posedge clock) disable iff (!rst_n)
        r_q.init |-> (ram_we && ram_wdata == freq_of(sel_of(STARTUP_MODE), r_q.xin)))
        else $error("start-up frequency not stored");

    switch_done_c: cover property (@(posedge clock) disable iff (!rst_n)
        r_q.st == SCSS_ST_REL ##1 r_q.st == SCSS_ST_RUN);
    pll_mode_c: cover property (@(posedge clock) disable iff (!rst_n)
        r_q.act == SCSS_SEL_X16 && sys_clk_out);
    refused_c: cover property (@(posedge clock) disable iff (!rst_n)
        mode_wr && !mode_ok(wdata[7:0]));
endmodule

// File: verif/scss_xtal_model.sv
// far-side model: crystal or clock oscillator on the input pin, plus the pll vco level
// assumes the 200 MHz bench clock; levels change just after a rising edge
`timescale 1ns/1ps
module scss_xtal_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // controls seen from the device
    input  wire logic       osc_en,
    input  wire logic       pll_en,
    input  wire logic       xo_oe,
    input  wire logic [1:0] load,
    // levels toward the device
    output logic            xi,
    output logic            vco
);
    logic [5:0] ph_q;
    logic       run;

    // a crystal only swings while driven; a clock pack on the input needs no drive
    assign run = osc_en && (xo_oe || load == 2'h0);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ph_q <= 6'h00;
        end else if (run) begin
            ph_q <= ph_q + 6'h01;
        end
    end

    // a stopped crystal rests at its bias level rather than the last swing
    assign xi  = run ? ph_q[5] : 1'b0;
    // vco at sixteen times the crystal, only while the pll is on
    assign vco = (run && pll_en) ? ph_q[1] : 1'b0;
endmodule

// File: verif/system_clock_source_select_tb.sv
// self-checking bench for the clock source selector
// assumes the design at 200 MHz with the switch wait shortened to 8 cycles
`timescale 1ns/1ps
module system_clock_source_select_tb;
    import scss_pkg::*;
    localparam int SW = 8;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [3:0]  addr  = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        fast_o = 1'b0;
    logic        slow_o = 1'b0;
    logic [31:0] rdata, d, xin;
    logic [31:0] lf = 32'd77449;
    logic        xi, vco, xo, xo_oe, osc_en, pll_en, sclk, busy;
    logic        mon = 1'b0;
    logic [1:0]  load;
    logic [7:0]  cur = 8'h00;
    logic [7:0]  m;
    logic [7:0]  modes[$];
    logic [7:0]  bad[5] = '{8'h02, 8'h03, 8'h23, 8'h07, 8'h27};
    int          errors = 0;
    int          n_compared = 0;
    int          fc = 0;
    int          sc = 0;
    int          hi = 0;

    scss_top #(.STARTUP_MODE(8'h00), .SWITCH_CYCLES_P(SW)) i_dut (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .fast_osc_in(fast_o), .slow_osc_in(slow_o),
        .crystal_input_pin(xi), .pll_vco_in(vco), .crystal_output_pin_o(xo),
        .crystal_output_pin_oe(xo_oe), .feedback_load(load),
        .oscillator_enable_bit(osc_en), .multiplier_enable_bit(pll_en),
        .sys_clk_out(sclk), .switch_busy(busy));

    scss_xtal_model i_xtal (
        .clock(clock), .rst_n(rst_n), .osc_en(osc_en), .pll_en(pll_en),
        .xo_oe(xo_oe), .load(load), .xi(xi), .vco(vco));

    initial begin
        forever #2.5 clock = ~clock;
    end

    // internal oscillators: fast period 6 cycles, slow period 14 cycles
    always @(posedge clock) begin
        fc <= (fc == 2) ? 0 : fc + 1;
        sc <= (sc == 6) ? 0 : sc + 1;
        if (fc == 2) fast_o <= ~fast_o;
        if (sc == 6) slow_o <= ~slow_o;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        v = rdata;
    endtask

    // busy must span the full wait plus the swap and release steps
    task automatic wait_sw(input logic moved);
        int n;
        n = 0;
        #1;
        chk(busy, moved, "busy after mode write");
        while (busy === 1'b1 && n < 300) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (moved) chk(n >= SW + 2, 1'b1, "switch too short");
        chk(busy, 1'b0, "switch hang");
    endtask

    task automatic rises(input int per);
        int  r;
        logic p;
        r = 0;
        p = sclk;
        repeat (384) begin
            @(posedge clock);
            #1;
            if (sclk === 1'b1 && p === 1'b0) r++;
            p = sclk;
        end
        chk((r - 384 / per) inside {-1, 0, 1}, 1'b1, "system clock rate");
    endtask

    function automatic logic [31:0] efreq(input logic [2:0] s, input logic [31:0] x);
        if (s == 3'h0) return SCSS_FAST_NOM_HZ;
        if (s == 3'h1) return SCSS_SLOW_NOM_HZ;
        if (s == 3'h2) return x;
        return x << (s - 3'h3);
    endfunction

    function automatic int per(input logic [2:0] s);
        if (s == 3'h0) return 6;
        if (s == 3'h1) return 14;
        if (s == 3'h2) return 64;
        return 64 >> (s - 3'h3);
    endfunction

    // crystal frequency outside the band of the chosen drive level
    function automatic logic erng(input logic [7:0] v, input logic [31:0] x);
        if (v[2:0] < 3'h2) return 1'b0;
        if (v[4:3] == 2'h0) return x > SCSS_XIN_MAX_HZ;
        if (v[4:3] == 2'h1) return (x < SCSS_LOW_MIN_HZ) || (x > SCSS_LOW_MAX_HZ);
        if (v[4:3] == 2'h2) return (x < SCSS_MED_MIN_HZ) || (x > SCSS_MED_MAX_HZ);
        return (x < SCSS_HIGH_MIN_HZ) || (x > SCSS_HIGH_MAX_HZ);
    endfunction

    function automatic logic [31:0] step(input logic [31:0] v);
        return {1'b0, v[31:1]} ^ (v[0] ? 32'h8020_0003 : 32'h0000_0000);
    endfunction

    // a high pulse of one cycle would be a clipped clock edge
    always @(posedge clock) begin
        if (sclk === 1'b1) begin
            hi <= hi + 1;
        end else begin
            if (mon && hi > 0) chk(hi >= 2, 1'b1, "short clock pulse");
            hi <= 0;
        end
    end

    initial begin
        repeat (60000) @(posedge clock);
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        bus_rd(SCSS_OFF_MODE, d);
        chk(d, 32'h0, "startup mode");
        bus_rd(SCSS_OFF_FREQ, d);
        chk(d, SCSS_FAST_NOM_HZ, "startup freq");
        rises(6);
        mon = 1'b1;
        $display("test startup done");
        foreach (bad[i]) begin
            bus_wr(SCSS_OFF_MODE, {24'h0, bad[i]});
            wait_sw(1'b0);
            bus_rd(SCSS_OFF_MODE, d);
            chk(d, 32'h0, "refused mode kept");
            bus_rd(SCSS_OFF_STAT, d);
            chk(d[2], 1'b1, "refusal flag");
            bus_wr(SCSS_OFF_STAT, 32'h4);
            bus_rd(SCSS_OFF_STAT, d);
            chk(d[2], 1'b0, "refusal clear");
        end
        bus_wr(4'h1, 32'hFF);
        bus_rd(4'h1, d);
        chk(d, 32'h0, "unmapped read");
        $display("test refusal done");
        modes = {8'h01, 8'h22, 8'h2A, 8'h32, 8'h3A};
        for (int v = 0; v < 4; v++) begin
            for (int s = 3; s < 8; s++) begin
                modes.push_back(8'(96 + v * 8 + s));
            end
        end
        modes.push_back(8'h00);
        foreach (modes[i]) begin
            m = modes[i];
            lf = step(lf);
            xin = 32'd4_000_000 + lf % 32'd12_000_000;
            bus_wr(SCSS_OFF_XIN, xin);
            // return to the fast source before touching the oscillator bits
            bus_wr(SCSS_OFF_MODE, {24'h0, cur[7:3], 3'h0});
            wait_sw(cur[2:0] != 3'h0);
            bus_wr(SCSS_OFF_MODE, {24'h0, m[7:3], 3'h0});
            repeat (20) @(posedge clock);
            bus_wr(SCSS_OFF_MODE, {24'h0, m});
            wait_sw(m[2:0] != 3'h0);
            chk({xo_oe, load, osc_en, pll_en},
                {27'h0, m[5] && |m[4:3], m[5] ? m[4:3] : 2'h0, m[5], m[6]}, "pins");
            // the output pin carries the inverted input level of the cycle before
            d[0] = xi;
            @(posedge clock);
            #1;
            chk(xo, (m[5] && |m[4:3]) ? !d[0] : 1'b0, "crystal drive");
            bus_rd(SCSS_OFF_MODE, d);
            chk(d, {24'h0, m}, "mode readback");
            bus_rd(SCSS_OFF_FREQ, d);
            chk(d, efreq(m[2:0], xin), "freq word");
            bus_rd(SCSS_OFF_STAT, d);
            chk(d & 32'h73, {25'h0, m[2:0], 2'h0, erng(m, xin), 1'b0}, "status");
            rises(per(m[2:0]));
            cur = m;
        end
        $display("test modes done");
        complete_run();
    end
endmodule
